// >>> tb_vreg_bank.sv
// Testbench for the voltage register bank.
`timescale 1ns/1ns
`default_nettype none
module tb_vreg_bank;
    import vreg_pkg::*;
    logic        clk, rst_n, wr_en, rd_en, strap, undervoltage_lockout, warm_n, por, rtc_low, go, go_done;
    logic [7:0]  addr, wdata, rdata, rv, units;
    logic [2:0]  pin_a, pin_b, fc, sc, slew;
    logic [4:0]  code;
    logic [15:0] mv;
    int          mismatches, check_count;
    vreg_bank dut_u (.i_clk(clk), .i_rst_n(rst_n), .i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr),
        .i_wdata(wdata), .o_rdata(rdata), .i_core_default_select_pin(strap), .i_regulator_default_pin_a(pin_a),
        .i_regulator_default_pin_b(pin_b), .i_undervoltage_lockout(undervoltage_lockout), .i_warm_reset_pin_n(warm_n),
        .i_power_on_reset_output(por), .i_clock_backup_supply_low(rtc_low), .i_go(go), .o_go_done(go_done),
        .o_core_code(code), .o_core_mv(mv), .o_slew_code(slew), .o_slew_units(units),
        .o_first_reg_code(fc), .o_second_reg_code(sc));
    vreg_host host_u (.i_clk(clk), .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata),
        .i_rdata(rdata));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic finish_test;
        $display("Mismatches %0d, checks %0d", mismatches, check_count);
        if (mismatches == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        host_u.rd(a, rv);
        chk("register read", {8'h00, e}, {8'h00, rv});
    endtask
    task automatic go_wait(input logic [4:0] t);
        int n;
        n = 0;
        @(posedge clk);
        go <= 1'b1;
        while (go_done !== 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        go <= 1'b0;
        if (n == 3000) begin
            mismatches++;
            finish_test();
        end
        #1 chk("core code", {11'h000, t}, {11'h000, code});
    endtask
    initial begin
        {rst_n, strap, undervoltage_lockout, por, rtc_low, go, warm_n} = 7'h01;
        pin_a = 3'h3;
        pin_b = 3'h5;
        mismatches = 0;
        check_count = 0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rchk(CORE_TARGET_OFS, 8'h14);
        rchk(SLEW_SELECT_OFS, 8'h06);
        host_u.wr(CORE_TARGET_OFS, 8'hFF);
        rchk(CORE_TARGET_OFS, 8'h1F);
        host_u.wr(REG_VOLTAGE_OFS, 8'hFF);
        rchk(REG_VOLTAGE_OFS, 8'h77);
        chk("regulator codes", 16'h0077, {9'h000, sc, 1'b0, fc});
        host_u.wr(8'h09, 8'h5A);
        rchk(8'h09, 8'h00);
        for (int k = 0; k < 8; k++) begin
            host_u.wr(SLEW_SELECT_OFS, 8'(k) | 8'hF8);
            #1 chk("slew units", (k == 7) ? 16'h0000 : 16'h0001 << k, {8'h00, units});
        end
        rchk(SLEW_SELECT_OFS, 8'h07);
        chk("slew code", 16'h0007, {13'h0000, slew});
        go_wait(5'h1F);
        chk("core mv", 16'h0640, mv);
        host_u.wr(SLEW_SELECT_OFS, 8'h06);
        host_u.wr(CORE_TARGET_OFS, 8'h1B);
        go_wait(5'h1B);
        chk("core mv", 16'h05C3, mv);
        @(posedge clk);
        undervoltage_lockout <= 1'b1;
        repeat (8) @(posedge clk);
        undervoltage_lockout <= 1'b0;
        repeat (4) @(posedge clk);
        rchk(CORE_TARGET_OFS, 8'h14);
        rchk(SLEW_SELECT_OFS, 8'h06);
        rchk(REG_VOLTAGE_OFS, 8'h53);
        chk("regulator codes", 16'h0053, {9'h000, sc, 1'b0, fc});
        strap <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            host_u.wr(CORE_TARGET_OFS, 8'h00);
            @(posedge clk);
            warm_n <= (k != 0);
            por <= (k == 1);
            rtc_low <= (k == 2);
            undervoltage_lockout <= (k == 3);
            repeat (6) @(posedge clk);
            rchk(CORE_TARGET_OFS, 8'h1E);
            {warm_n, por, rtc_low, undervoltage_lockout} <= 4'h8;
            repeat (4) @(posedge clk);
        end
        finish_test();
    end
endmodule
`default_nettype wire

// >>> vreg_bank.sv
// Core and linear regulator voltage register bank with strap defaults and reload events.
`timescale 1ns/1ns
`default_nettype none
module vreg_bank (
    input  wire logic        i_clk,                        // System clock, 100 MHz.
    input  wire logic        i_rst_n,                      // Synchronous reset, active low.
    input  wire logic        i_wr_en,                      // Register write strobe from serial interface.
    input  wire logic        i_rd_en,                      // Register read strobe from serial interface.
    input  wire logic [7:0]  i_addr,                       // Register offset.
    input  wire logic [7:0]  i_wdata,                      // Write data.
    output logic      [7:0]  o_rdata,                      // Read data, registered.
    input  wire logic        i_core_default_select_pin,    // Core strap, high selects 1.55 V.
    input  wire logic [2:0]  i_regulator_default_pin_a,    // First regulator default code.
    input  wire logic [2:0]  i_regulator_default_pin_b,    // Second regulator default code.
    input  wire logic        i_undervoltage_lockout,       // Lockout active, high.
    input  wire logic        i_warm_reset_pin_n,           // Warm reset pin, low active.
    input  wire logic        i_power_on_reset_output,      // Power-on reset output active, high.
    input  wire logic        i_clock_backup_supply_low,    // Backup supply below threshold.
    input  wire logic        i_go,                         // Voltage-change trigger bit from control reg.
    output logic             o_go_done,                    // Pulse: applied code reached target.
    output logic      [4:0]  o_core_code,                  // Code now applied to the core rail.
    output logic      [15:0] o_core_mv,                    // Applied core voltage in millivolts.
    output logic      [2:0]  o_slew_code,                  // Selected slew code.
    output logic      [7:0]  o_slew_units,                 // Ramp rate in 0.225 mV/us units, 0 immediate.
    output logic      [2:0]  o_first_reg_code,             // First regulator code.
    output logic      [2:0]  o_second_reg_code             // Second regulator code.
);
    import vreg_pkg::*;

    // Pins pass two flip-flops before use.
    logic [10:0] sync1_q;
    logic [10:0] sync2_q;
    logic [10:0] pins;
    assign pins = {i_core_default_select_pin, i_regulator_default_pin_a, i_regulator_default_pin_b,
                   i_undervoltage_lockout, i_warm_reset_pin_n, i_power_on_reset_output,
                   i_clock_backup_supply_low};
    always_ff @(posedge i_clk) begin
        sync1_q <= pins;
        sync2_q <= sync1_q;
    end

    logic       strap_core;
    logic [2:0] strap_a;
    logic [2:0] strap_b;
    logic       undervoltage_lockout;
    logic       core_reload;
    assign strap_core  = sync2_q[10];
    assign strap_a     = sync2_q[9:7];
    assign strap_b     = sync2_q[6:4];
    assign undervoltage_lockout        = sync2_q[3];
    assign core_reload = sync2_q[3] | ~sync2_q[2] | sync2_q[1] | sync2_q[0];

    // The strap is read continuously, so a reload always takes the correct default.
    logic [7:0] core_default;
    assign core_default = {3'h0, CORE_MSB_DEFAULT[4], strap_core ? CORE_LOW_VCC : CORE_LOW_GND};

    vreg_wr_if core_if ();
    vreg_wr_if slew_if ();
    vreg_wr_if ldo_if ();

    assign core_if.we    = i_wr_en && (i_addr == CORE_TARGET_OFS);
    assign core_if.wdata = i_wdata;
    assign core_if.load  = core_reload;
    assign core_if.ldata = core_default;

    assign slew_if.we    = i_wr_en && (i_addr == SLEW_SELECT_OFS);
    assign slew_if.wdata = i_wdata;
    assign slew_if.load  = undervoltage_lockout;
    assign slew_if.ldata = {5'h00, SLEW_RESET};

    assign ldo_if.we     = i_wr_en && (i_addr == REG_VOLTAGE_OFS);
    assign ldo_if.wdata  = i_wdata;
    assign ldo_if.load   = undervoltage_lockout;
    assign ldo_if.ldata  = {1'b0, strap_b, 1'b0, strap_a};

    // Reset values: core from the synchronised strap, regulators to code 0 until the first lockout event.
    vreg_field #(.MASK(8'h1F)) u_core (
        .i_clk    (i_clk),
        .i_rst_n  (i_rst_n),
        .i_rst_val(core_default),
        .port     (core_if.field)
    );
    vreg_field #(.MASK(8'h07)) u_slew (
        .i_clk    (i_clk),
        .i_rst_n  (i_rst_n),
        .i_rst_val({5'h00, SLEW_RESET}),
        .port     (slew_if.field)
    );
    vreg_field #(.MASK(8'h77)) u_ldo (
        .i_clk    (i_clk),
        .i_rst_n  (i_rst_n),
        .i_rst_val(8'h00),
        .port     (ldo_if.field)
    );

    logic [4:0] target;
    assign target            = core_if.value[4:0];
    assign o_slew_code       = slew_if.value[2:0];
    assign o_second_reg_code = ldo_if.value[SECOND_CODE_LSB +: 3];
    assign o_first_reg_code  = ldo_if.value[FIRST_CODE_LSB +: 3];

    // Read data.
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    always_comb begin
        rdata_d = rdata_q;
        if (!i_rst_n) begin
            rdata_d = 8'h00;
        end else if (i_rd_en) begin
            unique case (i_addr)
                CORE_TARGET_OFS: rdata_d = core_if.value;
                SLEW_SELECT_OFS: rdata_d = slew_if.value;
                REG_VOLTAGE_OFS: rdata_d = ldo_if.value;
                default:         rdata_d = 8'h00;
            endcase
        end
    end
    always_ff @(posedge i_clk) begin
        rdata_q <= rdata_d;
    end
    assign o_rdata = rdata_q;

    // Slew rate: code 0 is one unit, each step doubles, code 7 means immediate.
    always_comb begin
        if (o_slew_code == SLEW_IMMEDIATE) begin
            o_slew_units = 8'h00;
        end else begin
            o_slew_units = SLEW_BASE_UNIT << o_slew_code;
        end
    end

    // Step period in cycles halves with each slew code step.
    logic [4:0]  applied_q;
    logic [4:0]  applied_d;
    logic [13:0] tick_q;
    logic [13:0] tick_d;
    logic        done_q;
    logic        done_d;
    logic [13:0] step_len;
    assign step_len = 14'(STEP_BASE_CYCLES >> o_slew_code);

    typedef enum logic [0:0] {IDLE, RAMP} ramp_e;
    ramp_e st_q;
    ramp_e st_d;

    always_comb begin
        st_d      = st_q;
        applied_d = applied_q;
        tick_d    = tick_q;
        done_d    = 1'b0;
        if (!i_rst_n) begin
            st_d      = IDLE;
            applied_d = core_default[4:0];
            tick_d    = 14'h0000;
        end else begin
            unique case (st_q)
                IDLE: begin
                    // The trigger bit still reads set in the cycle of the done pulse; that must not restart.
                    if (i_go && !done_q) begin
                        st_d   = RAMP;
                        tick_d = 14'h0000;
                    end
                end
                RAMP: begin
                    if (applied_q == target) begin
                        st_d   = IDLE;
                        done_d = 1'b1;
                    end else if (o_slew_code == SLEW_IMMEDIATE) begin
                        applied_d = target;
                    end else if (tick_q >= step_len - 14'h0001) begin
                        tick_d    = 14'h0000;
                        applied_d = (applied_q < target) ? applied_q + 5'h01 : applied_q - 5'h01;
                    end else begin
                        tick_d = tick_q + 14'h0001;
                    end
                end
            endcase
        end
    end
    always_ff @(posedge i_clk) begin
        st_q      <= st_d;
        applied_q <= applied_d;
        tick_q    <= tick_d;
        done_q    <= done_d;
    end
    assign o_go_done   = done_q;
    assign o_core_code = applied_q;

    // Voltage of the applied code.
    always_comb begin
        if (applied_q == 5'h1F) begin
            o_core_mv = CORE_TOP_MV;
        end else begin
            o_core_mv = CORE_BASE_MV + CORE_STEP_MV * {11'h000, applied_q};
        end
    end
endmodule
`default_nettype wire

// >>> vreg_bank_properties.sv
// Concurrent checks on the ports of the voltage register bank.
`timescale 1ns/1ns
`default_nettype none
module vreg_bank_properties
    import vreg_pkg::*;
(
    input wire logic        i_clk,                     // Clock.
    input wire logic        i_rst_n,                   // Reset.
    input wire logic        i_wr_en,                   // Write.
    input wire logic        i_rd_en,                   // Read.
    input wire logic [7:0]  i_addr,                    // Offset.
    input wire logic [7:0]  i_wdata,                   // Data.
    input wire logic [7:0]  o_rdata,                   // Read data.
    input wire logic        i_core_default_select_pin, // Strap.
    input wire logic [2:0]  i_regulator_default_pin_a, // Pins a.
    input wire logic [2:0]  i_regulator_default_pin_b, // Pins b.
    input wire logic        i_undervoltage_lockout,    // Lockout.
    input wire logic        i_warm_reset_pin_n,        // Warm reset.
    input wire logic        i_go,                      // Trigger.
    input wire logic        o_go_done,                 // Done.
    input wire logic [4:0]  o_core_code,               // Code.
    input wire logic [15:0] o_core_mv,                 // Millivolts.
    input wire logic [2:0]  o_slew_code,               // Slew.
    input wire logic [7:0]  o_slew_units,              // Rate.
    input wire logic [2:0]  o_first_reg_code,          // First.
    input wire logic [2:0]  o_second_reg_code          // Second.
);
    logic [7:0] wd_q;
    always_ff @(posedge i_clk) begin
        wd_q <= i_wdata;
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    AST_CORE_MV: assert property (o_core_mv == ((o_core_code == 5'h1F) ? CORE_TOP_MV
        : CORE_BASE_MV + CORE_STEP_MV * o_core_code)) else $error("core mv wrong");
    AST_SLEW_UNITS: assert property (o_slew_units == ((o_slew_code == SLEW_IMMEDIATE) ? 8'h00
        : SLEW_BASE_UNIT << o_slew_code)) else $error("slew units wrong");
    AST_SLEW_WRITE: assert property ((!i_undervoltage_lockout [*4] ##0 i_wr_en && i_addr == SLEW_SELECT_OFS)
        |=> o_slew_code == wd_q[2:0]) else $error("slew write lost");
    AST_REG_WRITE: assert property ((!i_undervoltage_lockout [*4] ##0 i_wr_en && i_addr == REG_VOLTAGE_OFS)
        |=> {o_second_reg_code, o_first_reg_code} == {wd_q[6:4], wd_q[2:0]}) else $error("reg write lost");
    AST_SLEW_RELOAD: assert property (i_undervoltage_lockout [*6] |-> o_slew_code == SLEW_RESET)
        else $error("slew not reloaded");
    AST_REG_RELOAD: assert property (i_undervoltage_lockout [*6] |-> o_first_reg_code == i_regulator_default_pin_a
        && o_second_reg_code == i_regulator_default_pin_b) else $error("reg not reloaded");
    AST_CORE_RELOAD: assert property ((!i_warm_reset_pin_n [*6] ##0 i_rd_en && i_addr == CORE_TARGET_OFS)
        |=> o_rdata == {4'h1, i_core_default_select_pin ? CORE_LOW_VCC : CORE_LOW_GND}) else $error("core default");
    AST_RSVD_ZERO: assert property (i_rd_en |=> !o_rdata[7] && (!o_rdata[3] || $past(i_addr) != REG_VOLTAGE_OFS))
        else $error("reserved bit set");
    AST_DONE_PULSE: assert property (o_go_done |=> !o_go_done) else $error("done not a pulse");
    AST_GO_IMMEDIATE: assert property (($rose(i_go) && o_slew_code == SLEW_IMMEDIATE) |-> ##[1:4] o_go_done)
        else $error("immediate change slow");
    cover property (o_go_done);
    cover property (i_undervoltage_lockout [*6]);
    cover property (!i_warm_reset_pin_n [*6] ##0 i_rd_en);
endmodule
bind vreg_bank vreg_bank_properties chk_u (.*);
`default_nettype wire

// >>> vreg_field.sv
// One register field with write mask and a default reload that wins over a write.
`timescale 1ns/1ns
`default_nettype none
module vreg_field #(
    parameter logic [7:0] MASK = 8'hFF
) (
    input  wire logic   i_clk,   // System clock.
    input  wire logic   i_rst_n, // Synchronous reset, active low.
    input  wire logic [7:0] i_rst_val, // Value taken during reset.
    vreg_wr_if.field    port     // Write and reload strobes.
);
    logic [7:0] val_q;
    logic [7:0] val_d;

    always_comb begin
        val_d = val_q;
        if (!i_rst_n) begin
            val_d = i_rst_val & MASK;
        end else if (port.load) begin
            val_d = port.ldata & MASK;
        end else if (port.we) begin
            val_d = port.wdata & MASK;
        end
    end

    always_ff @(posedge i_clk) begin
        val_q <= val_d;
    end

    assign port.value = val_q;
endmodule
`default_nettype wire

// >>> vreg_host.sv
// Host model issuing single-byte register writes and reads.
`timescale 1ns/1ns
`default_nettype none
module vreg_host
    import vreg_pkg::*;
(
    input  wire logic       i_clk,   // Clock.
    output logic            o_wr_en, // Write strobe.
    output logic            o_rd_en, // Read strobe.
    output logic      [7:0] o_addr,  // Offset.
    output logic      [7:0] o_wdata, // Write data.
    input  wire logic [7:0] i_rdata  // Read data.
);
    initial begin
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_addr = 8'h00;
        o_wdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_wr_en <= 1'b1;
        o_addr <= a;
        o_wdata <= (a == REG_VOLTAGE_OFS) ? (d & 8'h77) : d;
        @(posedge i_clk);
        o_wr_en <= 1'b0;
        o_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_rd_en <= 1'b1;
        o_addr <= a;
        @(posedge i_clk);
        o_rd_en <= 1'b0;
        @(posedge i_clk);
        d = i_rdata;
    endtask
endmodule
`default_nettype wire

// >>> vreg_pkg.sv
// Package with offsets, field layouts and reset values of the voltage register bank.
package vreg_pkg;
    localparam logic [7:0] CORE_TARGET_OFS  = 8'h06;
    localparam logic [7:0] SLEW_SELECT_OFS  = 8'h07;
    localparam logic [7:0] REG_VOLTAGE_OFS  = 8'h08;
    localparam logic [4:0] CORE_MSB_DEFAULT = 5'h10;
    localparam logic [3:0] CORE_LOW_GND     = 4'h4;
    localparam logic [3:0] CORE_LOW_VCC     = 4'hE;
    localparam logic [2:0] SLEW_RESET       = 3'h6;
    localparam logic [2:0] SLEW_IMMEDIATE   = 3'h7;
    localparam int         SECOND_CODE_LSB  = 4;
    localparam int         FIRST_CODE_LSB   = 0;
    // Voltages in millivolts per code.
    localparam logic [15:0] CORE_BASE_MV    = 16'h0320;
    localparam logic [15:0] CORE_STEP_MV    = 16'h0019;
    localparam logic [15:0] CORE_TOP_MV     = 16'h0640;
    // Ramp rate in units of 0.225 mV/us, code 000 is one unit.
    localparam logic [7:0]  SLEW_BASE_UNIT  = 8'h01;
    // Cycles for one 25 mV step at the slowest rate, about 111 us at 100 MHz.
    localparam int unsigned STEP_BASE_CYCLES = 11111;
endpackage

// >>> vreg_wr_if.sv
// Interface carrying one register write strobe between the bank and its field store.
`timescale 1ns/1ns
`default_nettype none
interface vreg_wr_if;
    logic       we;
    logic [7:0] wdata;
    logic       load;
    logic [7:0] ldata;
    logic [7:0] value;
    modport bank (output we, output wdata, output load, output ldata, input value);
    modport field (input we, input wdata, input load, input ldata, output value);
endinterface
`default_nettype wire
